// file: design/host_port_pkg.sv
// shared types and constants for the host-side parallel bus controller
package host_port_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // bus style chosen by the two strap pins, coded as {sel_hi, sel_lo}
  typedef enum logic [1:0] {
    HT_RW_ACK    = 2'b00,  // read/write line, lower strobe on a0, acknowledge
    HT_STB_WAIT  = 2'b01,  // separate strobes, active-low wait, word only
    HT_STB_READY = 2'b10,  // separate strobes, active-high ready, word only
    HT_BYTE_WAIT = 2'b11   // byte-addressed separate strobes, active-low wait
  } host_type_t;

  ////////////////////////////////////////////////////////////////////////////////
  // pin widths and map layout
  localparam int unsigned ADDR_W    = 10;     // a0..a9
  localparam int unsigned DATA_W    = 16;     // d0..d15
  localparam int unsigned REG_W     = 32;     // one device register
  localparam logic [7:0]  CMD_OFS   = 8'h00;  // command byte within an axis
  localparam logic [7:0]  BUF_OFS   = 8'h04;  // first byte of the i/o buffer
  localparam logic [7:0]  RED_MASK  = 8'h07;  // a3..a7 not wired when reduced
  localparam logic [2:0]  BYTE_XFRS = 3'h4;   // transfers per register, bytes
  localparam logic [2:0]  WORD_XFRS = 3'h2;   // transfers per register, words

  ////////////////////////////////////////////////////////////////////////////////
  // timing, in device clocks (device clock is ref_clk_i)
  localparam logic [3:0] DEV_RST_CLKS = 4'h8;                 // reset low, least
  localparam logic [3:0] RD_MIN_CLKS  = 4'h4;                 // strobe must exceed
  localparam logic [3:0] STROBE_CLKS  = RD_MIN_CLKS + 4'h1;   // strobe without wait
  localparam logic [3:0] WAIT_SMP_CLKS = 4'h2;                // strobe before sampling

  ////////////////////////////////////////////////////////////////////////////////
  // one register access asked for by the user
  typedef struct packed {
    logic              write;     // 1 write, 0 read
    logic              indirect;  // go through the i/o buffer
    logic [1:0]        axis;      // drives a9,a8
    logic [7:0]        offset;    // register offset within the axis
    logic [7:0]        cmd;       // register write or readout command code
    logic [REG_W-1:0]  wdata;     // value to write
  } host_req_t;

  // one strobe cycle on the pins
  typedef struct packed {
    logic              write;     // 1 write, 0 read
    logic [ADDR_W-1:0] addr;      // a9..a0
    logic [DATA_W-1:0] wdata;     // data to drive
  } bus_op_t;

endpackage : host_port_pkg

// file: design/strobe_cycle.sv
// one strobe cycle on the device pins, with wait or fixed-length stretching
`timescale 1ns/100ps
module strobe_cycle
  import host_port_pkg::*;
(
  input  wire logic              ref_clk_i,     // 100 mhz clock
  input  wire logic              srst_i,        // sync reset, high
  input  wire logic              start_i,       // one-cycle start pulse
  input  wire bus_op_t           op_i,          // cycle to run
  input  wire host_type_t        host_type_i,   // bus style
  input  wire logic              use_wait_i,    // honour the wait pin
  input  wire logic              wait_pin_i,    // wait / ack / ready pin
  input  wire logic              busy_n_i,      // interface busy, low busy
  input  wire logic [DATA_W-1:0] data_i,        // data bus in
  output logic                   rd_n_o,        // read strobe
  output logic                   wr_n_o,        // write strobe or r/w line
  output logic [ADDR_W-1:0]      addr_o,        // address pins
  output logic [DATA_W-1:0]      data_o,        // data bus out
  output logic                   data_oe_o,     // data bus enable, high drives
  output logic [DATA_W-1:0]      rdata_o,       // data caught at strobe end
  output logic                   done_o         // one-cycle end pulse
);

  ////////////////////////////////////////////////////////////////////////////////
  // states
  typedef enum logic [2:0] {
    SC_IDLE   = 3'b000,  // nothing running
    SC_BUSYCK = 3'b001,  // wait for interface not busy
    SC_SETUP  = 3'b010,  // address and data settle
    SC_STROBE = 3'b011,  // strobe low
    SC_HOLD   = 3'b100   // strobe released, data held
  } sc_state_t;

  sc_state_t  state_ff;  // cycle state
  bus_op_t    op_ff;     // latched cycle
  logic [3:0] cnt_ff;    // clocks spent in strobe
  logic       ack_mode;  // read/write-line style
  logic       go_on;     // pin says the device is done
  logic       strobe_end;

  assign ack_mode = (host_type_i == HT_RW_ACK);
  // acknowledge is low-true, wait and ready both high when free
  assign go_on    = ack_mode ? ~wait_pin_i : wait_pin_i;

  assign strobe_end = use_wait_i ? ((cnt_ff >= WAIT_SMP_CLKS - 4'h1) && go_on)
                                 : (cnt_ff == STROBE_CLKS);

  ////////////////////////////////////////////////////////////////////////////////
  // sequence and pins
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      state_ff  <= SC_IDLE;
      op_ff     <= '0;
      cnt_ff    <= 4'h0;
      rd_n_o    <= 1'b1;
      wr_n_o    <= 1'b1;
      addr_o    <= '0;
      data_o    <= '0;
      data_oe_o <= 1'b0;
      rdata_o   <= '0;
      done_o    <= 1'b0;
    end else begin
      done_o <= 1'b0;
      unique case (state_ff)
        SC_IDLE: begin
          if (start_i) begin
            op_ff <= op_i;
            state_ff <= use_wait_i ? SC_SETUP : SC_BUSYCK;
          end
        end
        SC_BUSYCK: begin
          if (busy_n_i) begin
            state_ff <= SC_SETUP;
          end
        end
        SC_SETUP: begin
          // a0 is the lower strobe, wr is r/w
          addr_o    <= ack_mode ? {op_ff.addr[ADDR_W-1:1], 1'b1} : op_ff.addr;
          wr_n_o    <= ack_mode ? ~op_ff.write : 1'b1;
          data_o    <= op_ff.wdata;
          data_oe_o <= op_ff.write;
          cnt_ff    <= 4'h0;
          state_ff  <= SC_STROBE;
        end
        SC_STROBE: begin
          cnt_ff <= cnt_ff + 4'h1;
          if (cnt_ff == 4'h0) begin
            // first strobe clock: assert the style's strobe
            if (ack_mode) begin
              addr_o[0] <= 1'b0;
            end else if (op_ff.write) begin
              wr_n_o <= 1'b0;
            end else begin
              rd_n_o <= 1'b0;
            end
          end
          if (strobe_end && (cnt_ff != 4'h0)) begin
            rdata_o   <= data_i;
            rd_n_o    <= 1'b1;
            addr_o[0] <= ack_mode ? 1'b1 : addr_o[0];
            wr_n_o    <= ack_mode ? ~op_ff.write : 1'b1;
            state_ff  <= SC_HOLD;
          end
        end
        SC_HOLD: begin
          // data held one clock past the strobe
          data_oe_o <= 1'b0;
          wr_n_o    <= 1'b1;
          done_o    <= 1'b1;
          state_ff  <= SC_IDLE;
        end
        default: begin
          state_ff <= SC_IDLE;
        end
      endcase
    end
  end

endmodule : strobe_cycle

// file: design/host_bus_controller.sv
// host-side controller driving the pulse device's parallel cpu port
`timescale 1ns/100ps
module host_bus_controller
  import host_port_pkg::*;
(
  input  wire logic              ref_clk_i,             // 100 mhz clock
  input  wire logic              srst_i,                // sync reset, high
  input  wire logic              host_type_sel_hi_i,    // bus style strap, high
  input  wire logic              host_type_sel_lo_i,    // bus style strap, low
  input  wire logic              reduced_wiring_i,      // board uses reduced address
  input  wire logic              use_wait_i,            // wait pin is wired
  input  wire logic              dev_reset_req_i,       // pulse: reset the device
  input  wire logic              req_valid_i,           // request present
  input  wire host_req_t         req_i,                 // request contents
  output logic                   busy_o,                // request in progress
  output logic                   done_o,                // one-cycle finish pulse
  output logic [REG_W-1:0]       rdata_o,               // register read value
  output logic                   dev_rst_n_o,           // device reset, low
  output logic                   rd_n_o,                // read strobe
  output logic                   wr_n_o,                // write strobe or r/w
  output logic [ADDR_W-1:0]      addr_o,                // address pins a9..a0
  output logic [DATA_W-1:0]      data_o,                // data bus out
  output logic                   data_oe_o,             // data bus enable
  input  wire logic [DATA_W-1:0] data_i,                // data bus in
  input  wire logic              host_wait_request_n_i, // wait / ack / ready pin
  input  wire logic              iface_busy_n_i         // interface busy, low
);

  ////////////////////////////////////////////////////////////////////////////////
  // declarations

  typedef enum logic [1:0] {
    MS_RESET = 2'b00,  // device held in reset
    MS_IDLE  = 2'b01,  // ready for a request
    MS_ISSUE = 2'b10,  // start one strobe cycle
    MS_WAIT  = 2'b11   // strobe cycle running
  } ms_state_t;

  ms_state_t         state_ff;       // sequencer state
  host_type_t        host_type_ff;   // caught strap setting
  logic              reduced_ff;     // caught wiring setting
  host_req_t         req_ff;         // request being served
  logic              indirect_ff;    // request goes through buffer
  logic [2:0]        step_ff;        // strobe cycle index
  logic [2:0]        nsteps_ff;      // strobe cycles for request
  logic [3:0]        rst_cnt_ff;     // reset hold counter
  logic              dev_rst_n_ff;   // device reset pin
  logic              start_ff;       // start pulse to cycle engine
  bus_op_t           op_ff;          // cycle handed to engine
  logic [REG_W-1:0]  rdata_ff;       // assembled read value
  logic              done_ff;        // finish pulse
  logic              busy_ff;        // busy level

  logic              cyc_done;       // engine finished a cycle
  logic [DATA_W-1:0] cyc_rdata;      // engine read data

  // combinational step descriptor
  logic              byte_mode;      // eight-bit transfers
  logic              upper_first;    // upper half sits at lower address
  logic [2:0]        xfers;          // data transfers per register
  logic              is_cmd;         // this step writes the command
  logic [1:0]        k;              // data transfer index
  logic              half;           // word half for this transfer
  logic [7:0]        ofs;            // offset within the axis
  bus_op_t           nxt_op;         // cycle for this step

  ////////////////////////////////////////////////////////////////////////////////
  // strap capture

  // straps caught while the device is held in reset
  always_ff @(posedge ref_clk_i) begin
    if (srst_i || (state_ff == MS_RESET)) begin
      host_type_ff <= host_type_t'({host_type_sel_hi_i, host_type_sel_lo_i});
      reduced_ff   <= reduced_wiring_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // step descriptor

  // style properties
  always_comb begin
    byte_mode   = (host_type_ff == HT_BYTE_WAIT);
    upper_first = (host_type_ff == HT_RW_ACK) || (host_type_ff == HT_STB_WAIT);
    xfers       = byte_mode ? BYTE_XFRS : WORD_XFRS;
  end

  // address and data for the current step
  always_comb begin
    is_cmd = indirect_ff && (req_ff.write ? (step_ff == xfers) : (step_ff == 3'h0));
    if (indirect_ff && !req_ff.write) begin
      k = 2'(step_ff - 3'h1);        // skip the leading command
    end else begin
      k = step_ff[1:0];              // data first
    end
    half = upper_first ? ~k[0] : k[0];

    if (is_cmd) begin
      ofs = CMD_OFS;
    end else if (byte_mode) begin
      ofs = (indirect_ff ? BUF_OFS : req_ff.offset) + {6'h00, k};
    end else begin
      ofs = (indirect_ff ? BUF_OFS : req_ff.offset) + {5'h00, k[0], 1'b0};
    end

    if (reduced_ff) begin
      ofs = ofs & RED_MASK;
    end

    nxt_op.addr  = {req_ff.axis, ofs};
    nxt_op.write = is_cmd ? 1'b1 : req_ff.write;

    // data lanes for the step
    if (is_cmd) begin
      nxt_op.wdata = (upper_first && !byte_mode) ? {req_ff.cmd, 8'h00}
                                                 : {8'h00, req_ff.cmd};
    end else if (byte_mode) begin
      nxt_op.wdata = {8'h00, req_ff.wdata[{k, 3'b000} +: 8]};
    end else begin
      nxt_op.wdata = req_ff.wdata[{half, 4'h0} +: DATA_W];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // request sequencer

  // walks the strobe cycles of one request
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      state_ff    <= MS_RESET;
      req_ff      <= '0;
      indirect_ff <= 1'b0;
      step_ff     <= 3'h0;
      nsteps_ff   <= 3'h0;
      start_ff    <= 1'b0;
      op_ff       <= '0;
    end else begin
      start_ff <= 1'b0;
      unique case (state_ff)
        MS_RESET: begin
          // leave once the device reset is released
          if (dev_rst_n_ff) begin
            state_ff <= MS_IDLE;
          end
        end
        MS_IDLE: begin
          if (dev_reset_req_i) begin
            state_ff <= MS_RESET;
          end else if (req_valid_i) begin
            req_ff      <= req_i;
            // buffer path forced on reduced wiring
            indirect_ff <= req_i.indirect || reduced_ff;
            nsteps_ff   <= xfers + {2'b00, (req_i.indirect || reduced_ff)};
            step_ff     <= 3'h0;
            state_ff    <= MS_ISSUE;
          end
        end
        MS_ISSUE: begin
          op_ff    <= nxt_op;
          start_ff <= 1'b1;
          state_ff <= MS_WAIT;
        end
        MS_WAIT: begin
          if (cyc_done) begin
            if (step_ff == nsteps_ff - 3'h1) begin
              state_ff <= MS_IDLE;
            end else begin
              step_ff  <= step_ff + 3'h1;
              state_ff <= MS_ISSUE;
            end
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // device reset

  // hold the device reset low for the full count
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      rst_cnt_ff   <= 4'h0;
      dev_rst_n_ff <= 1'b0;
    end else if ((state_ff == MS_IDLE) && dev_reset_req_i) begin
      // restart the hold
      rst_cnt_ff   <= 4'h0;
      dev_rst_n_ff <= 1'b0;
    end else if (!dev_rst_n_ff) begin
      if (rst_cnt_ff == DEV_RST_CLKS - 4'h1) begin
        dev_rst_n_ff <= 1'b1;
      end else begin
        rst_cnt_ff <= rst_cnt_ff + 4'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read data assembly

  // pieces land in their register lanes
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      rdata_ff <= '0;
    end else if ((state_ff == MS_IDLE) && req_valid_i && !dev_reset_req_i) begin
      rdata_ff <= '0;
    end else if ((state_ff == MS_WAIT) && cyc_done && !is_cmd && !req_ff.write) begin
      if (byte_mode) begin
        rdata_ff[{k, 3'b000} +: 8] <= cyc_rdata[7:0];
      end else begin
        rdata_ff[{half, 4'h0} +: DATA_W] <= cyc_rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // status

  // busy level and finish pulse
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      busy_ff <= 1'b1;
      done_ff <= 1'b0;
    end else begin
      done_ff <= (state_ff == MS_WAIT) && cyc_done && (step_ff == nsteps_ff - 3'h1);
      if (state_ff == MS_IDLE) begin
        busy_ff <= req_valid_i || dev_reset_req_i;
      end else if ((state_ff == MS_RESET) && dev_rst_n_ff) begin
        busy_ff <= 1'b0;
      end else if (state_ff == MS_WAIT) begin
        busy_ff <= !(cyc_done && (step_ff == nsteps_ff - 3'h1));
      end
    end
  end

  assign busy_o      = busy_ff;
  assign done_o      = done_ff;
  assign rdata_o     = rdata_ff;
  assign dev_rst_n_o = dev_rst_n_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // strobe cycle engine

  strobe_cycle u_cycle (
    .ref_clk_i   (ref_clk_i),
    .srst_i      (srst_i),
    .start_i     (start_ff),
    .op_i        (op_ff),
    .host_type_i (host_type_ff),
    .use_wait_i  (use_wait_i),
    .wait_pin_i  (host_wait_request_n_i),
    .busy_n_i    (iface_busy_n_i),
    .data_i      (data_i),
    .rd_n_o      (rd_n_o),
    .wr_n_o      (wr_n_o),
    .addr_o      (addr_o),
    .data_o      (data_o),
    .data_oe_o   (data_oe_o),
    .rdata_o     (cyc_rdata),
    .done_o      (cyc_done)
  );

endmodule : host_bus_controller

// file: bench/host_bus_controller_checker.sv
// port-level assertions for the host-side parallel bus controller
`timescale 1ns/100ps
module host_bus_controller_checker
  import host_port_pkg::*;
(
  input wire logic              ref_clk_i, // clock
  input wire logic              srst_i, // sync reset
  input wire logic              host_type_sel_hi_i, // strap high
  input wire logic              host_type_sel_lo_i, // strap low
  input wire logic              reduced_wiring_i, // reduced address
  input wire logic              use_wait_i, // wait pin wired
  input wire logic              dev_reset_req_i, // device reset ask
  input wire logic              req_valid_i, // request present
  input wire host_req_t         req_i, // request contents
  input wire logic              busy_o, // busy
  input wire logic              dev_rst_n_o, // device reset
  input wire logic              rd_n_o, // read strobe
  input wire logic              wr_n_o, // write strobe
  input wire logic [ADDR_W-1:0] addr_o, // address pins
  input wire logic              data_oe_o, // data enable
  input wire logic              host_wait_request_n_i, // wait pin
  input wire logic              iface_busy_n_i // busy pin
);
  logic [3:0] low_cnt;  // clocks of device reset so far
  logic [1:0] axis_q;   // axis of the request in service
  logic [1:0] style;    // strap code
  logic       strb;     // read or write line low
  assign style = {host_type_sel_hi_i, host_type_sel_lo_i};
  assign strb  = !(rd_n_o && wr_n_o);

  ////////////////////////////////////////////////////////////////////////////////
  // count device reset low time, saturating
  always_ff @(posedge ref_clk_i) begin
    if (srst_i || dev_rst_n_o) low_cnt <= 4'h0;
    else if (low_cnt != 4'hF) low_cnt <= low_cnt + 4'h1;
  end

  // remember the axis of each taken request
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) axis_q <= 2'h0;
    else if (req_valid_i && !busy_o && !dev_reset_req_i) axis_q <= req_i.axis;
  end

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);

  // a strobe held past four device clocks
  sequence s_long_strobe;
    strb [*5];
  endsequence

  rst_hold_a: assert property ($rose(dev_rst_n_o) |-> low_cnt >= 4'h8)
    else $error("reset too short");
  rst_busy_a: assert property (!dev_rst_n_o |-> busy_o)
    else $error("idle in reset");
  rd_tied_a: assert property (style == 2'b00 |-> rd_n_o)
    else $error("read strobe used");
  a0_ground_a: assert property (style inside {2'b01, 2'b10} |-> !addr_o[0])
    else $error("odd address in word style");
  wait_stall_a: assert property (style != 2'b00 && use_wait_i && strb
      && !host_wait_request_n_i |=> strb)
    else $error("stall ignored");
  strobe_len_a: assert property (!use_wait_i && style != 2'b00 && $rose(strb)
      |-> s_long_strobe)
    else $error("strobe too short");
  busy_seen_a: assert property (!use_wait_i && $rose(strb) |-> $past(iface_busy_n_i))
    else $error("strobe while busy");
  no_contend_a: assert property (style != 2'b00 && !rd_n_o |-> !data_oe_o)
    else $error("bus driven during read");
  axis_pins_a: assert property (style != 2'b00 && strb |-> addr_o[9:8] == axis_q)
    else $error("wrong axis on a9 a8");
  reduced_a: assert property (reduced_wiring_i && strb |-> addr_o[7:3] == 5'h00)
    else $error("unwired bit driven");
endmodule : host_bus_controller_checker

bind host_bus_controller host_bus_controller_checker u_chk (.*);

// file: bench/pulse_dev_model.sv
// behavioural pulse device as seen through its parallel cpu port
`timescale 1ns/100ps
module pulse_dev_model
  import host_port_pkg::*;
(
  input  wire logic              ref_clk_i,   // device clock
  input  wire logic [1:0]        style_i,     // straps {hi,lo}
  input  wire logic              reduced_i,   // reduced wiring
  input  wire logic [3:0]        wait_clks_i, // stall per strobe, at least 1
  input  wire logic              dev_rst_n_i, // device reset, low
  input  wire logic              rd_n_i,      // read strobe
  input  wire logic              wr_n_i,      // write strobe or r/w
  input  wire logic [ADDR_W-1:0] addr_i,      // address pins
  input  wire logic [DATA_W-1:0] data_i,      // data from host
  output logic      [DATA_W-1:0] data_o,      // data to host
  output logic                   wait_pin_o,  // wait / ack / ready
  output logic                   busy_n_o     // interface busy, low
);
  logic [DATA_W-1:0] mem [1024]; // one entry per pin address
  logic [3:0]        cnt;        // clocks into the strobe
  logic [2:0]        busy_cnt;   // internal transfer left
  logic [DATA_W-1:0] last;       // last value on the bus
  logic [ADDR_W-1:0] a;          // decoded address
  logic [7:0]        cmd;        // command byte lane
  logic              act;        // cycle in progress
  // cycle detect per bus style
  assign act = dev_rst_n_i && ((style_i == 2'b00) ? !addr_i[0] : !(rd_n_i && wr_n_i));
  // reduced wiring decodes a0,a1,a2,a8,a9 only
  assign a   = reduced_i ? (addr_i & 10'h306) | {9'h0, addr_i[0]} : addr_i;
  assign cmd = style_i[1] ? data_i[7:0] : data_i[15:8];
  // released bus shows a changing pattern
  assign data_o   = (act && wr_n_i) ? mem[{a[9:1], a[0] & (style_i == 2'b11)}] : ~last;
  // pending internal transfer
  assign busy_n_o = (busy_cnt == 3'h0);

  // stall, then release per style
  always_comb begin
    if (!act) wait_pin_o = (style_i != 2'b10);
    else if (cnt >= wait_clks_i) wait_pin_o = (style_i != 2'b00);
    else wait_pin_o = (style_i == 2'b00);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // strobe timing and busy countdown
  always_ff @(posedge ref_clk_i) begin
    last <= data_o;
    if (!dev_rst_n_i) begin
      cnt      <= 4'h0;
      busy_cnt <= 3'h0;
    end else begin
      cnt      <= !act ? 4'h0 : (cnt == 4'hF) ? cnt : cnt + 4'h1;
      busy_cnt <= (act && !wr_n_i && cnt == wait_clks_i) ? 3'h3 :
                  (busy_cnt != 3'h0) ? busy_cnt - 3'h1 : busy_cnt;
    end
  end

  // writes; commands move buffer and register
  always_ff @(posedge ref_clk_i) begin
    if (act && !wr_n_i && cnt == wait_clks_i) begin
      mem[{a[9:1], a[0] & (style_i == 2'b11)}] <= data_i;
      if (a[7:0] == CMD_OFS) begin
        for (int k = 0; k < 4; k++) begin
          if (cmd[7]) mem[{a[9:8], cmd[5:0], 2'b00} + k] <= mem[{a[9:8], 8'h04} + k];
          else mem[{a[9:8], 8'h04} + k] <= mem[{a[9:8], cmd[5:0], 2'b00} + k];
        end
      end
    end
  end
endmodule : pulse_dev_model

// file: bench/host_bus_controller_bench.sv
// self-checking bench for the host-side parallel bus controller
`timescale 1ns/100ps
module host_bus_controller_bench
  import host_port_pkg::*;
  ;
  logic ref_clk_i, srst_i, host_type_sel_hi_i, host_type_sel_lo_i; // clock, reset, straps
  logic reduced_wiring_i, use_wait_i, dev_reset_req_i, req_valid_i; // controls
  host_req_t         req_i; // request
  logic              busy_o, done_o, dev_rst_n_o, rd_n_o, wr_n_o, data_oe_o; // status, pins
  logic [REG_W-1:0]  rdata_o; // read value
  logic [ADDR_W-1:0] addr_o; // address pins
  logic [DATA_W-1:0] data_o, data_i; // data bus halves
  logic              host_wait_request_n_i, iface_busy_n_i; // device pins
  logic [3:0]        wait_clks; // device stall
  int                err_total, samples_checked; // counters

  always #5 ref_clk_i = ~ref_clk_i;

  host_bus_controller uut (.*);

  pulse_dev_model u_dev (
    .ref_clk_i   (ref_clk_i),
    .style_i     ({host_type_sel_hi_i, host_type_sel_lo_i}),
    .reduced_i   (reduced_wiring_i),
    .wait_clks_i (wait_clks),
    .dev_rst_n_i (dev_rst_n_o),
    .rd_n_i      (rd_n_o),
    .wr_n_i      (wr_n_o),
    .addr_i      (addr_o),
    .data_i      (data_o),
    .data_o      (data_i),
    .wait_pin_o  (host_wait_request_n_i),
    .busy_n_o    (iface_busy_n_i)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk

  // bounded wait for the finish pulse or for idle
  task automatic wait_on(input bit want_done);
    int n;
    n = 0;
    while (want_done ? done_o !== 1'b1 : busy_o !== 1'b0) begin
      @(negedge ref_clk_i);
      n++;
      if (n > 3000) begin
        err_total++;
        $display("unexpected at %0t: wait ran out", $time);
        report_and_stop();
      end
    end
  endtask : wait_on

  // count negedges until the device leaves reset
  task automatic count_rst();
    int n;
    n = 0;
    while (dev_rst_n_o !== 1'b1 && n < 40) begin
      @(negedge ref_clk_i);
      n++;
    end
    chk(n, {28'h0, DEV_RST_CLKS}, "reset length");
  endtask : count_rst

  task automatic do_reset(input logic [1:0] st, input logic red);
    srst_i = 1'b1;
    {host_type_sel_hi_i, host_type_sel_lo_i} = st;
    reduced_wiring_i = red;
    repeat (20) @(negedge ref_clk_i);
    srst_i = 1'b0;
    count_rst();
  endtask : do_reset

  task automatic run_req(input logic w, input logic ind, input logic [1:0] ax,
                         input logic [7:0] ofs, input logic [7:0] cm, input logic [31:0] wd);
    wait_on(1'b0);
    req_i = '{write: w, indirect: ind, axis: ax, offset: ofs, cmd: cm, wdata: wd};
    req_valid_i = 1'b1;
    @(negedge ref_clk_i);
    req_valid_i = 1'b0;
    wait_on(1'b1);
  endtask : run_req

  ////////////////////////////////////////////////////////////////////////////////
  // direct write and read back in one style, axis equal to style code
  task automatic t_direct(input logic [1:0] st);
    logic [31:0] v;
    logic [15:0] first;
    v = 32'hA5C3_1E70 + {30'h0, st};
    first = (st == 2'b11) ? {8'h00, v[7:0]} : (st == 2'b10) ? v[15:0] : v[31:16];
    do_reset(st, 1'b0);
    use_wait_i = 1'b1;
    wait_clks = 4'h2 + {2'h0, st};
    run_req(1'b1, 1'b0, st, 8'h08, 8'h00, v);
    chk({16'h0, u_dev.mem[{st, 8'h08}] & ((st == 2'b11) ? 16'h00FF : 16'hFFFF)},
        {16'h0, first}, "first unit");
    run_req(1'b0, 1'b0, st, 8'h08, 8'h00, 32'h0000_0000);
    chk(rdata_o, v, "direct read");
  endtask : t_direct

  // buffer write, second register, then readout of the first
  task automatic t_indirect(input logic red);
    do_reset(2'b11, red);
    use_wait_i = 1'b1;
    wait_clks = 4'h5;
    run_req(1'b1, 1'b1, 2'b10, 8'h0C, 8'h83, 32'h1357_9BDF);
    chk({24'h0, u_dev.mem[10'h20C][7:0]}, 32'h0000_00DF, "register loaded");
    run_req(1'b1, 1'b1, 2'b10, 8'h10, 8'h84, 32'h2468_ACE0);
    run_req(1'b0, 1'b1, 2'b10, 8'h0C, 8'h03, 32'h0000_0000);
    chk(rdata_o, 32'h1357_9BDF, "indirect read");
  endtask : t_indirect

  // fixed long strobe with busy check, then a device reset request
  task automatic t_nowait();
    do_reset(2'b01, 1'b0);
    use_wait_i = 1'b0;
    wait_clks = 4'h4;
    run_req(1'b1, 1'b0, 2'b01, 8'h10, 8'h00, 32'h0F1E_2D3C);
    run_req(1'b0, 1'b0, 2'b01, 8'h10, 8'h00, 32'h0000_0000);
    chk(rdata_o, 32'h0F1E_2D3C, "read without wait");
    dev_reset_req_i = 1'b1;
    @(negedge ref_clk_i);
    dev_reset_req_i = 1'b0;
    count_rst();
  endtask : t_nowait

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk_i = 1'b0;
    srst_i = 1'b1;
    {host_type_sel_hi_i, host_type_sel_lo_i, reduced_wiring_i} = 3'h0;
    {use_wait_i, dev_reset_req_i, req_valid_i} = 3'h4;
    req_i = '0;
    wait_clks = 4'h2;
    err_total = 0;
    samples_checked = 0;
    @(negedge ref_clk_i);
    for (int s = 0; s < 4; s++) begin
      t_direct(s[1:0]);
    end
    t_indirect(1'b0);
    t_indirect(1'b1);
    t_nowait();
    report_and_stop();
  end
endmodule : host_bus_controller_bench
